/* File: hw/dht_regs.svh */
`ifndef DHT_REGS_SVH
`define DHT_REGS_SVH

// ************************************************************
// register addresses on the host port
// ************************************************************
`define DHT_A_DATA   3'h0
`define DHT_A_ERROR  3'h1
`define DHT_A_SCNT   3'h2
`define DHT_A_SNUM   3'h3
`define DHT_A_CYLLO  3'h4
`define DHT_A_CYLHI  3'h5
`define DHT_A_SDH    3'h6
`define DHT_A_STAT   3'h7

// ************************************************************
// status bits
// ************************************************************
`define DHT_ST_BUSY  7
`define DHT_ST_RDY   6
`define DHT_ST_XREQ  3
`define DHT_ST_CORR  2
`define DHT_ST_ERR   0

// ************************************************************
// command byte fields
// ************************************************************
`define DHT_OP_RESTORE 4'h1
`define DHT_OP_READ    4'h2
`define DHT_OP_SEEK    4'h7
`define DHT_CMD_DMA    3
`define DHT_CMD_RATE   3:0
`define DHT_ERR_ABORT  8'h04

// ************************************************************
// reset values and sizes
// ************************************************************
`define DHT_RATE_RST   4'h0
`define DHT_RATE_FAST  4'h0
`define DHT_SCNT_LAST  8'h01
`define DHT_BYTE_LAST  8'hff
`define DHT_CYLHI_W    2

// ************************************************************
// timing
// ************************************************************
`define DHT_CLK_NS       20
`define DHT_STEP_FAST_NS 35000
`define DHT_STEP_FAST_CYC ((`DHT_STEP_FAST_NS) / (`DHT_CLK_NS))
`define DHT_STEP_SLOW_US 500
`define DHT_STEP_SLOW_CYC ((`DHT_STEP_SLOW_US) * 1000 / (`DHT_CLK_NS))

`endif

/* File: hw/dht_pkg.sv */
package dht_pkg;
  // controller sequencing states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEEK,
    ST_FILL,
    ST_XFER,
    ST_DONE
  } dht_state_type;
endpackage

/* File: hw/dht_transfer_ctrl.sv */
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`include "dht_regs.svh"
// Overview of operation
// - busy status bit 7 is set at command start, cleared when host may talk
// - interrupt line rises each time the host must step in, e.g. completion
// - error register is only meaningful while the error flag is set
// - error flag in bit 0, corrected flag in bit 2, mask 5 covers both
// - every command but a good programmed read completes through done; errors show only in status
// - read with dma bit clear interrupts before the buffer goes to host
// - read with dma bit set interrupts after the whole buffer is moved
// - all data goes through a full sector buffer, drained at host pace
// - transfer request line rises once for every byte to move
// - dma read moves sector count sectors, zero meaning 256; a programmed read moves one
// - after dma success count reads zero, number is last sector plus one
// - after fatal error number is failing sector, count is sectors left
// - correctable error sets corrected flag and the read carries on
// - reads may stop partway; completion then comes from the dma side
// - command bit 4 is 0 for read, 1 for all other commands
// - any access to cylinder low clears the transfer request line
// - read performs an implied seek with the stored implied rate
// - restore and seek take explicit rates; seek rate is kept for later
module dht_transfer_ctrl #(
  parameter int STEP_SLOW_CYC = `DHT_STEP_SLOW_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata_ff,
  output logic             host_interrupt_line_ff,
  output logic             byte_transfer_request_ff,
  input  wire logic        drive_ready,
  input  wire logic        seek_done,
  input  wire logic        dsk_byte_vld,
  input  wire logic [7:0]  dsk_byte,
  input  wire logic        dsk_sector_done,
  input  wire logic        dsk_corrected,
  input  wire logic        dsk_fatal,
  input  wire logic [7:0]  dsk_err_code,
  output logic             seek_req_ff,
  output logic      [19:0] step_period_ff,
  output logic      [9:0]  seek_cyl_ff,
  output logic             read_req_ff,
  output logic      [7:0]  sec_num_ff,
  output logic      [7:0]  sdh_ff
);

  // ************************************************************
  // state
  // ************************************************************
  dht_pkg::dht_state_type state_ff;
  logic [7:0]  cmd_ff;
  logic        busy_ff;
  logic        err_ff;
  logic        corr_ff;
  logic [7:0]  err_reg_ff;
  logic [7:0]  sec_cnt_ff;
  logic [7:0]  cyl_lo_ff;
  logic [1:0]  cyl_hi_ff;
  logic [3:0]  implied_rate_ff;
  logic [7:0]  xptr_ff;
  logic [7:0]  fptr_ff;
  logic        req_hold_ff;
  logic        rdy_meta_ff;
  logic        rdy_sync_ff;
  logic [7:0]  sector_buf [256];
  logic [7:0]  rd_mux;

  // ************************************************************
  // decode
  // ************************************************************
  // opcode decoders, shared by the sequencer and the rate logic
  function automatic logic is_read(input logic [7:0] c);
    return c[7:4] == `DHT_OP_READ;
  endfunction

  function automatic logic is_seek(input logic [7:0] c);
    return c[7:4] == `DHT_OP_SEEK;
  endfunction

  function automatic logic is_restore(input logic [7:0] c);
    return c[7:4] == `DHT_OP_RESTORE;
  endfunction

  // code 0 is the fast rate, every other code scales the slow unit
  function automatic logic [19:0] rate_cyc(input logic [3:0] code);
    if (code == `DHT_RATE_FAST) begin
      return 20'(`DHT_STEP_FAST_CYC);
    end
    return 20'(code * STEP_SLOW_CYC);
  endfunction

  // strobes decoded once and shared by the processes below
  logic cmd_wr;
  logic cmd_ok;
  logic cmd_known;
  logic data_rd;
  logic last_rd;
  logic cyl_access;
  logic dma;
  logic irq_set;
  logic irq_clr;
  logic task_wr;

  assign cmd_wr     = wr && (addr == `DHT_A_STAT);
  // a new command may cut short a sector still being drained
  assign cmd_ok     = cmd_wr && (state_ff == dht_pkg::ST_IDLE || state_ff == dht_pkg::ST_XFER);
  // anything else is aborted but still completes normally
  assign cmd_known  = is_read(wdata) || is_seek(wdata) || is_restore(wdata);
  // data reads outside the transfer phase leave the pointer alone
  assign data_rd    = rd && (addr == `DHT_A_DATA) && (state_ff == dht_pkg::ST_XFER);
  // the last byte of a sector ends the host side of that sector
  assign last_rd    = data_rd && (xptr_ff == `DHT_BYTE_LAST);
  assign cyl_access = (rd || wr) && (addr == `DHT_A_CYLLO);
  assign dma        = cmd_ff[`DHT_CMD_DMA];
  assign task_wr    = wr && !busy_ff;
  // done state completes all but a good programmed read, error or not; that one interrupts on sector fill
  assign irq_set    = (state_ff == dht_pkg::ST_DONE) ||
                      (state_ff == dht_pkg::ST_FILL && dsk_sector_done && !dsk_fatal && !dma);
  assign irq_clr    = cmd_wr || (rd && addr == `DHT_A_STAT);

  // ************************************************************
  // drive ready pin synchroniser
  // ************************************************************
  // a free running pin: two flops before the status mux reads it
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdy_meta_ff <= 1'b0;
      rdy_sync_ff <= 1'b0;
    end else begin
      rdy_meta_ff <= drive_ready;
      rdy_sync_ff <= rdy_meta_ff;
    end
  end

  // ************************************************************
  // command sequencer
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff    <= dht_pkg::ST_IDLE;
      cmd_ff      <= 8'h00;
      busy_ff     <= 1'b0;
      err_ff      <= 1'b0;
      corr_ff     <= 1'b0;
      err_reg_ff  <= 8'h00;
      xptr_ff     <= 8'h00;
      seek_req_ff <= 1'b0;
      read_req_ff <= 1'b0;
    end else begin
      // both requests are one cycle pulses unless raised below
      seek_req_ff <= 1'b0;
      read_req_ff <= 1'b0;
      if (cmd_ok) begin
        cmd_ff  <= wdata;
        busy_ff <= 1'b1;
        err_ff  <= 1'b0;
        corr_ff <= 1'b0;
        if (cmd_known) begin
          state_ff    <= dht_pkg::ST_SEEK;
          seek_req_ff <= 1'b1;
        end else begin
          // unsupported commands still finish like any other
          err_ff     <= 1'b1;
          err_reg_ff <= `DHT_ERR_ABORT;
          state_ff   <= dht_pkg::ST_DONE;
        end
      end else begin
        unique case (state_ff)
          dht_pkg::ST_IDLE: begin
            // nothing pending; new commands are taken above
          end
          dht_pkg::ST_SEEK: begin
            if (seek_done) begin
              if (is_read(cmd_ff)) begin
                state_ff    <= dht_pkg::ST_FILL;
                read_req_ff <= 1'b1;
              end else begin
                state_ff <= dht_pkg::ST_DONE;
              end
            end
          end
          dht_pkg::ST_FILL: begin
            // a corrected sector is only noted; a fatal one skips the host transfer
            if (dsk_corrected) begin
              corr_ff <= 1'b1;
            end
            if (dsk_fatal) begin
              err_ff     <= 1'b1;
              err_reg_ff <= dsk_err_code;
              state_ff   <= dht_pkg::ST_DONE;
            end else if (dsk_sector_done) begin
              xptr_ff  <= 8'h00;
              state_ff <= dht_pkg::ST_XFER;
              if (!dma) begin
                busy_ff <= 1'b0;
              end
            end
          end
          dht_pkg::ST_XFER: begin
            // the last byte decides: programmed reads stop, dma refills or finishes
            if (data_rd) begin
              xptr_ff <= xptr_ff + 8'h01;
            end
            if (last_rd) begin
              if (!dma) begin
                state_ff <= dht_pkg::ST_IDLE;
              end else if (sec_cnt_ff == `DHT_SCNT_LAST) begin
                state_ff <= dht_pkg::ST_DONE;
              end else begin
                state_ff    <= dht_pkg::ST_FILL;
                read_req_ff <= 1'b1;
              end
            end
          end
          dht_pkg::ST_DONE: begin
            // one cycle here raises the interrupt at the next edge
            busy_ff  <= 1'b0;
            state_ff <= dht_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // task file: host writes while not busy, sequencer steps sectors
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      sec_cnt_ff <= 8'h00;
      sec_num_ff <= 8'h00;
      cyl_lo_ff  <= 8'h00;
      cyl_hi_ff  <= 2'h0;
      sdh_ff     <= 8'h00;
    end else if (last_rd && dma) begin
      // only dma reads step the task file; a programmed read leaves it alone
      // count 0 wraps to 255, so zero moves 256 sectors
      sec_cnt_ff <= sec_cnt_ff - 8'h01;
      sec_num_ff <= sec_num_ff + 8'h01;
    end else if (task_wr) begin
      unique case (addr)
        `DHT_A_SCNT:  sec_cnt_ff <= wdata;
        `DHT_A_SNUM:  sec_num_ff <= wdata;
        `DHT_A_CYLLO: cyl_lo_ff  <= wdata;
        `DHT_A_CYLHI: cyl_hi_ff  <= wdata[`DHT_CYLHI_W-1:0];
        `DHT_A_SDH:   sdh_ff     <= wdata;
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // stepping rate and seek target
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      implied_rate_ff <= `DHT_RATE_RST;
      step_period_ff  <= 20'h00000;
      seek_cyl_ff     <= 10'h000;
    end else if (cmd_ok && cmd_known) begin
      seek_cyl_ff <= {cyl_hi_ff, cyl_lo_ff};
      // a restore rate is used once; only a seek rate is kept for implied seeks
      if (is_seek(wdata)) begin
        implied_rate_ff <= wdata[`DHT_CMD_RATE];
      end
      if (is_read(wdata)) begin
        step_period_ff <= rate_cyc(implied_rate_ff);
      end else begin
        step_period_ff <= rate_cyc(wdata[`DHT_CMD_RATE]);
      end
    end
  end

  // ************************************************************
  // sector buffer: disk fills at its speed, host drains at any pace
  // ************************************************************
  // the fill pointer restarts with every sector request
  always_ff @(posedge mclk) begin
    if (rst || read_req_ff) begin
      fptr_ff <= 8'h00;
    end else if (state_ff == dht_pkg::ST_FILL && dsk_byte_vld) begin
      fptr_ff <= fptr_ff + 8'h01;
    end
  end

  // no reset on the array: its contents only matter after a full fill
  always_ff @(posedge mclk) begin
    if (state_ff == dht_pkg::ST_FILL && dsk_byte_vld) begin
      sector_buf[fptr_ff] <= dsk_byte;
    end
  end

  // ************************************************************
  // transfer request line
  // ************************************************************
  // a dma engine stopped early would see a stale request on its next
  // setup, so a cylinder low access holds it off until a new command
  always_ff @(posedge mclk) begin
    if (rst) begin
      req_hold_ff <= 1'b0;
    end else if (cyl_access) begin
      req_hold_ff <= 1'b1;
    end else if (cmd_ok) begin
      // only an accepted command, the next legal transfer, lets it go
      req_hold_ff <= 1'b0;
    end
  end

  // low for one cycle after each byte read, so every byte gets a rising edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      byte_transfer_request_ff <= 1'b0;
    end else begin
      byte_transfer_request_ff <= (state_ff == dht_pkg::ST_XFER) && !req_hold_ff && !cyl_access &&
                                  !data_rd && !cmd_ok;
    end
  end

  // ************************************************************
  // host interrupt: set beats clear
  // ************************************************************
  // a clear landing on a completion would swallow its edge, so set wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      host_interrupt_line_ff <= 1'b0;
    end else if (irq_set) begin
      host_interrupt_line_ff <= 1'b1;
    end else if (irq_clr) begin
      host_interrupt_line_ff <= 1'b0;
    end
  end

  // ************************************************************
  // read data, valid only the cycle after the strobe
  // ************************************************************
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr)
      `DHT_A_DATA:  rd_mux = sector_buf[xptr_ff];
      `DHT_A_ERROR: rd_mux = err_reg_ff;
      `DHT_A_SCNT:  rd_mux = sec_cnt_ff;
      `DHT_A_SNUM:  rd_mux = sec_num_ff;
      `DHT_A_CYLLO: rd_mux = cyl_lo_ff;
      `DHT_A_CYLHI: rd_mux = {6'h00, cyl_hi_ff};
      `DHT_A_SDH:   rd_mux = sdh_ff;
      // reserved status bits keep the zero from the default above
      `DHT_A_STAT: begin
        rd_mux[`DHT_ST_BUSY] = busy_ff;
        rd_mux[`DHT_ST_RDY]  = rdy_sync_ff;
        rd_mux[`DHT_ST_XREQ] = byte_transfer_request_ff;
        rd_mux[`DHT_ST_CORR] = corr_ff;
        rd_mux[`DHT_ST_ERR]  = err_ff;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      // zero outside the answer cycle, so a stale byte never looks like data
      rdata_ff <= rd ? rd_mux : 8'h00;
    end
  end

endmodule // dht_transfer_ctrl

/* File: testbench/dht_transfer_ctrl_sva.sv */
`timescale 1ns/1ns
// ****
// port checker for the transfer control
// ****
module dht_transfer_ctrl_sva #(
  parameter int STEP_SLOW_CYC = 25000
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [2:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata_ff,
  input wire logic        host_interrupt_line_ff,
  input wire logic        byte_transfer_request_ff,
  input wire logic        seek_req_ff,
  input wire logic [19:0] step_period_ff
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // unused status bits must read zero
  stat_bits_a: assert property (rd && addr == 3'h7 |=> (rdata_ff & 8'h32) == 8'h00)
    else $error("status reserved bits set");
  // a pending interrupt means the host may talk, so busy is low
  idle_busy_a: assert property (rd && addr == 3'h7 && host_interrupt_line_ff |=> !rdata_ff[7])
    else $error("busy seen with interrupt pending");
  irq_drop_a: assert property (rd && addr == 3'h7 && host_interrupt_line_ff |=> !host_interrupt_line_ff)
    else $error("interrupt held after status read");
  cmd_drop_a: assert property (wr && addr == 3'h7 && host_interrupt_line_ff |=> !host_interrupt_line_ff)
    else $error("interrupt held after command");
  seek_go_a: assert property (wr && addr == 3'h7 && wdata[7:4] == 4'h7 && wdata[3:0] != 4'h0 &&
    host_interrupt_line_ff |=> seek_req_ff && step_period_ff == 20'($past(wdata[3:0]) * STEP_SLOW_CYC))
    else $error("seek start or rate wrong");
  fast_rate_a: assert property (wr && addr == 3'h7 && wdata == 8'h10 && host_interrupt_line_ff
    |=> seek_req_ff ##1 !seek_req_ff && step_period_ff == 20'd1750)
    else $error("fast step rate wrong");
  req_byte_a: assert property (byte_transfer_request_ff && rd && addr == 3'h0 |=> !byte_transfer_request_ff)
    else $error("request not dropped per byte");
  cyl_clear_a: assert property ((rd || wr) && addr == 3'h4 |=> !byte_transfer_request_ff [*3])
    else $error("request not cleared by cylinder access");
endmodule // dht_transfer_ctrl_sva

bind dht_transfer_ctrl dht_transfer_ctrl_sva #(.STEP_SLOW_CYC(STEP_SLOW_CYC)) dht_transfer_ctrl_sva_i (
  .mclk, .rst, .addr, .wdata, .wr, .rd, .rdata_ff, .host_interrupt_line_ff,
  .byte_transfer_request_ff, .seek_req_ff, .step_period_ff);

/* File: testbench/dht_disk_model.sv */
`timescale 1ns/1ns
// ****
// disk engine stand-in that fills the sector buffer
// ****
module dht_disk_model #(
  parameter logic [7:0] ERR_CODE = 8'h10
) (
  input  wire logic       mclk,
  input  wire logic       seek_req_ff,
  input  wire logic       read_req_ff,
  input  wire logic [7:0] sec_num_ff,
  input  wire logic [7:0] fatal_sec,
  input  wire logic [7:0] corr_sec,
  output logic            seek_done = 1'b0,
  output logic            dsk_byte_vld = 1'b0,
  output logic      [7:0] dsk_byte = 8'h00,
  output logic            dsk_sector_done = 1'b0,
  output logic            dsk_corrected = 1'b0,
  output logic            dsk_fatal = 1'b0,
  output logic      [7:0] dsk_err_code = 8'h00
);
  logic [7:0] s;
  // one job at a time; data lines churn when nothing qualifies them
  initial begin
    forever begin
      @(posedge mclk);
      dsk_byte <= ~dsk_byte;
      dsk_err_code <= ~dsk_err_code;
      if (seek_req_ff) begin
        repeat (5) @(posedge mclk);
        seek_done <= 1'b1;
        @(posedge mclk);
        seek_done <= 1'b0;
      end else if (read_req_ff) begin
        s = sec_num_ff;
        for (int i = 0; i < 256; i++) begin
          @(posedge mclk);
          dsk_byte_vld <= 1'b1;
          dsk_byte <= 8'(i) + s;
        end
        @(posedge mclk);
        dsk_byte_vld <= 1'b0;
        dsk_corrected <= (s == corr_sec);
        dsk_fatal <= (s == fatal_sec);
        dsk_err_code <= ERR_CODE;
        @(posedge mclk);
        dsk_corrected <= 1'b0;
        dsk_fatal <= 1'b0;
        dsk_sector_done <= (s != fatal_sec);
        @(posedge mclk);
        dsk_sector_done <= 1'b0;
      end
    end
  end
endmodule // dht_disk_model

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
// ****
// bench top: host and dma driver, read answer monitor
// ****
module testbench;
  localparam int SLOW = 4;
  logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00, s = 8'h00, fatal_sec = 8'h80, corr_sec = 8'h80, rdata_ff, sec_num_ff, sdh_ff;
  logic [7:0]  dsk_byte, dsk_err_code, exp_q[$];
  logic        host_interrupt_line_ff, byte_transfer_request_ff, seek_req_ff, read_req_ff, seek_done;
  logic        dsk_byte_vld, dsk_sector_done, dsk_corrected, dsk_fatal;
  logic [19:0] step_period_ff;
  logic [9:0]  seek_cyl_ff;
  logic [31:0] rnd = 32'd75590;
  int          err_count = 0, n_tests = 0;

  always #10 mclk = ~mclk;

  dht_transfer_ctrl #(.STEP_SLOW_CYC(SLOW)) dht_transfer_ctrl_i (.mclk, .rst, .addr, .wdata, .wr, .rd,
    .rdata_ff, .host_interrupt_line_ff, .byte_transfer_request_ff, .drive_ready(1'b1), .seek_done,
    .dsk_byte_vld, .dsk_byte, .dsk_sector_done, .dsk_corrected, .dsk_fatal, .dsk_err_code, .seek_req_ff,
    .step_period_ff, .seek_cyl_ff, .read_req_ff, .sec_num_ff, .sdh_ff);
  dht_disk_model dht_disk_model_i (.mclk, .seek_req_ff, .read_req_ff, .sec_num_ff, .fatal_sec, .corr_sec,
    .seek_done, .dsk_byte_vld, .dsk_byte, .dsk_sector_done, .dsk_corrected, .dsk_fatal, .dsk_err_code);

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // the note goes in before the strobe so the monitor never runs dry
  task automatic rd_exp(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask

  // bounded wait for the request line or the interrupt
  task automatic wait_on(input bit want_req);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while ((want_req ? byte_transfer_request_ff : host_interrupt_line_ff) !== 1'b1 && n < 3000);
    if (n >= 3000) chk("wait", 20'h1, 20'h0);
  endtask

  // dma style drain with random stalls between bytes
  task automatic get_bytes(input int cnt, input logic [7:0] b);
    for (int i = 0; i < cnt; i++) begin
      rnd = xs(rnd);
      repeat (rnd[1:0]) @(posedge mclk);
      wait_on(1'b1);
      rd_exp(3'h0, 8'(i) + b);
    end
  endtask

  // a read answer stands one cycle, so it is taken at the next edge
  always @(posedge mclk) begin
    rd_d <= rd;
    if (rd_d)
      chk("rdata", {12'h000, exp_q.pop_front()}, {12'h000, rdata_ff});
  end

  initial begin
    repeat (30000) @(posedge mclk);
    err_count++;
    test_done;
  end

  // ****
  // main sequence
  // ****
  initial begin
    rnd = xs(rnd);
    s = rnd[7:0];
    fatal_sec = s + 8'h80;
    corr_sec = s + 8'h80;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk); // the ready pin passes two flops before status shows it
    rd_exp(3'h7, 8'h40);
    wr_reg(3'h4, 8'h34);
    wr_reg(3'h5, 8'h01);
    wr_reg(3'h6, s);
    wr_reg(3'h7, 8'h10);
    wait_on(1'b0);
    chk("step", 20'd1750, step_period_ff);
    chk("cyl", 20'h00134, {10'h000, seek_cyl_ff});
    wr_reg(3'h7, 8'h73);
    wait_on(1'b0);
    rd_exp(3'h7, 8'h40);
    wr_reg(3'h3, s);
    wr_reg(3'h7, 8'h20);
    rd_exp(3'h7, 8'hc0);
    wr_reg(3'h6, ~s);
    wait_on(1'b0);
    chk("step", 20'(3 * SLOW), step_period_ff);
    chk("sdh", {12'h000, s}, {12'h000, sdh_ff});
    rd_exp(3'h7, 8'h48);
    get_bytes(256, s);
    rd_exp(3'h7, 8'h40);
    corr_sec = s;
    wr_reg(3'h2, 8'h02);
    wr_reg(3'h7, 8'h28);
    get_bytes(256, s);
    chk("irq", 20'h0, {19'h0, host_interrupt_line_ff});
    get_bytes(256, s + 8'h01);
    wait_on(1'b0);
    rd_exp(3'h7, 8'h44);
    rd_exp(3'h2, 8'h00);
    rd_exp(3'h3, s + 8'h02);
    corr_sec = s + 8'h80;
    fatal_sec = s + 8'h03;
    wr_reg(3'h2, 8'h03);
    wr_reg(3'h7, 8'h28);
    get_bytes(256, s + 8'h02);
    wait_on(1'b0);
    rd_exp(3'h7, 8'h41);
    rd_exp(3'h1, 8'h10);
    rd_exp(3'h2, 8'h02);
    rd_exp(3'h3, s + 8'h03);
    fatal_sec = s + 8'h80;
    wr_reg(3'h7, 8'h50);
    wait_on(1'b0);
    rd_exp(3'h1, 8'h04);
    wr_reg(3'h7, 8'h10);
    wait_on(1'b0);
    rd_exp(3'h7, 8'h40);
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h7, 8'h28);
    get_bytes(10, s + 8'h03);
    wait_on(1'b1);
    rd_exp(3'h4, 8'h34);
    @(posedge mclk);
    #1;
    chk("req", 20'h0, {19'h0, byte_transfer_request_ff});
    wr_reg(3'h7, 8'h10);
    wait_on(1'b0);
    rd_exp(3'h7, 8'h40);
    repeat (3) @(posedge mclk);
    test_done;
  end
endmodule // testbench
